//--- rtl/tecc_capture.sv
/*
 * Capture control: two capture registers and the routed external interrupt.
 * Assumes trigger inputs are synchronous to the clock.
 */
`timescale 1ns/100ps
`include "tecc_params.svh"

module tecc_capture
    import tecc_pkg::*;
#(
    parameter bit HAS_PINS = 1'b1
)(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [1:0]  i_mode,
    input  wire logic        i_companion,
    input  wire logic        i_pin,
    input  wire logic        i_tick,
    input  wire logic        i_sw_capture,
    input  wire logic [15:0] i_count,
    output logic [15:0]      o_cap0,
    output logic [15:0]      o_cap1,
    output logic             o_ext_irq
);
    logic comp_q, pin_q, pend0_q, pend1_q;
    logic src, src_prev, rise, fall;
    tecc_capm_t mode;

    assign mode      = tecc_capm_t'(i_mode);
    assign src       = (mode == TECC_CAP_PIN) ? i_pin : i_companion;
    assign src_prev  = (mode == TECC_CAP_PIN) ? pin_q : comp_q;
    assign rise      = src && !src_prev &&
                       ((mode == TECC_CAP_COMPANION) || (mode == TECC_CAP_PIN && HAS_PINS));
    assign fall      = !src && src_prev &&
                       ((mode == TECC_CAP_COMPANION) || (mode == TECC_CAP_PIN && HAS_PINS));
    assign o_ext_irq = HAS_PINS && i_pin && !pin_q;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            comp_q <= 1'b0;
            pin_q  <= 1'b0;
        end else begin
            comp_q <= i_companion;
            pin_q  <= i_pin;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pend0_q <= 1'b0;
            pend1_q <= 1'b0;
            o_cap0  <= 16'h0000;
            o_cap1  <= 16'h0000;
        end else begin
            if (i_sw_capture) begin
                o_cap0 <= i_count;
            end else if ((pend0_q || rise) && i_tick) begin
                o_cap0 <= i_count;
            end
            if ((pend1_q || fall) && i_tick) begin
                o_cap1 <= i_count;
            end
            pend0_q <= (pend0_q || rise) && !i_tick;
            pend1_q <= (pend1_q || fall) && !i_tick;
        end
    end
endmodule : tecc_capture

//--- rtl/tecc_channel.sv
/*
 * One 16-bit timer/event counter channel with compare, capture and APB slave.
 * Assumes one 100 MHz clock, synchronous active-high reset, synchronous pins.
 */
// Register access over APB was decided locally.
// How it works
// - Prescaler counts when run bit set, else cleared.
// - Prescaler input is clock divided by four.
// - Three taps with periods in ratio 1:4:16.
// - Counter source: external pin or one tap.
// - Channel run counts; cleared run stops and zeroes.
// - Clear-on-match returns counter to zero at compare one.
// - Counter overflow raises the overflow interrupt.
// - Two comparators raise match signals and interrupts.
// - Compare zero has buffer, enable bit resets low.
// - Buffer copies into compare zero on match one.
// - Shared address writes both, or buffer only.
// - Compare registers are write only.
// - Capture registers latch counter, read as whole.
// - Capture mode selects trigger source for capture.
// - Routed external interrupt is rising edge only.
// - Writing zero to software capture bit captures while prescaler runs.
// - Last channels lack pins and edge selection.
`timescale 1ns/100ps
`include "tecc_params.svh"

module tecc_channel
    import tecc_pkg::*;
#(
    parameter bit HAS_EXT_PINS = 1'b1
)(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [15:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_ext_clock_pin,
    input  wire logic        i_capture_input_pin,
    input  wire logic        i_companion_timer_output,
    output logic             o_match_a,
    output logic             o_match_b,
    output logic             o_match_irq_a,
    output logic             o_match_irq_b,
    output logic             o_overflow_irq,
    output logic             o_routed_ext_irq
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [7:0]  run_q, mode_q, status_q;
    logic [7:0]  cmp0_lo_q, cmp1_lo_q, cap0_hi_q, cap1_hi_q;
    logic [15:0] cmp0_q, cmp1_q, buf0_q, cnt_q;
    logic [15:0] cap0, cap1;
    logic [31:0] rdata_q;
    logic        err_q, ext_q, eq_a_q, eq_b_q;
    logic        prescaler_run, channel_run, dbuf_en, clear_en;
    logic        base_tick, tap_fine, tap_medium, tap_coarse, tick;
    logic        eq_a, eq_b, wrap, wr_en, rd_setup, sw_capture, mapped;
    logic [13:0] idx;
    logic [4:0]  pre_count;
    tecc_src_t   src_sel;

    assign prescaler_run = run_q[`TECC_RUN_PRE_BIT];
    assign channel_run   = run_q[`TECC_RUN_CH_BIT];
    assign dbuf_en       = run_q[`TECC_RUN_RDE_BIT];
    assign clear_en      = mode_q[`TECC_MODE_CLE_BIT];
    assign src_sel       = tecc_src_t'(mode_q[`TECC_MODE_CLK_LSB +: 2]);

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    assign idx      = i_paddr[15:2];
    assign wr_en    = i_psel && i_penable && i_pwrite;
    assign rd_setup = i_psel && !i_penable && !i_pwrite;
    assign o_pready = 1'b1;
    assign o_prdata = rdata_q;
    assign o_pslverr = err_q && i_psel && i_penable;

    always_comb begin
        if (i_paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else if (idx == `TECC_IDX_RUN || idx == `TECC_IDX_MODE ||
                     idx == `TECC_IDX_STATUS) begin
            mapped = 1'b1;
        end else if (idx >= `TECC_IDX_CMP0_LO && idx <= `TECC_IDX_CAP1_HI) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    assign sw_capture = wr_en && idx == `TECC_IDX_MODE && mapped &&
                        !i_pwdata[`TECC_MODE_SWC_BIT] && prescaler_run;

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            run_q  <= `TECC_RUN_RESET;
            mode_q <= `TECC_MODE_RESET;
        end else if (wr_en && mapped) begin
            if (idx == `TECC_IDX_RUN) begin
                run_q <= i_pwdata[7:0];
            end else if (idx == `TECC_IDX_MODE) begin
                mode_q <= i_pwdata[7:0] | (8'h01 << `TECC_MODE_SWC_BIT);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Compare registers and buffer
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cmp0_lo_q <= 8'h00;
            cmp1_lo_q <= 8'h00;
            cmp0_q    <= 16'h0000;
            cmp1_q    <= 16'h0000;
            buf0_q    <= 16'h0000;
        end else begin
            if (wr_en && idx == `TECC_IDX_CMP0_LO && mapped) begin
                cmp0_lo_q <= i_pwdata[7:0];
            end
            if (wr_en && idx == `TECC_IDX_CMP1_LO && mapped) begin
                cmp1_lo_q <= i_pwdata[7:0];
            end
            if (wr_en && idx == `TECC_IDX_CMP1_HI && mapped) begin
                cmp1_q <= {i_pwdata[7:0], cmp1_lo_q};
            end
            if (wr_en && idx == `TECC_IDX_CMP0_HI && mapped) begin
                buf0_q <= {i_pwdata[7:0], cmp0_lo_q};
                if (!dbuf_en) begin
                    cmp0_q <= {i_pwdata[7:0], cmp0_lo_q};
                end
            end else if (dbuf_en && o_match_irq_b) begin
                cmp0_q <= buf0_q;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Prescaler and count source
    // ------------------------------------------------------------------------
    tecc_prescaler u_pre (
        .i_clk        (i_clk),
        .i_sys_rst    (i_sys_rst),
        .i_run        (prescaler_run),
        .o_base_tick  (base_tick),
        .o_tap_fine   (tap_fine),
        .o_tap_medium (tap_medium),
        .o_tap_coarse (tap_coarse),
        .o_count      (pre_count)
    );

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= i_ext_clock_pin;
        end
    end

    always_comb begin
        case (src_sel)
            TECC_SRC_EXT:    tick = HAS_EXT_PINS && i_ext_clock_pin && !ext_q;
            TECC_SRC_FINE:   tick = tap_fine;
            TECC_SRC_MED:    tick = tap_medium;
            TECC_SRC_COARSE: tick = tap_coarse;
            default:         tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // Up-counter and comparators
    // ------------------------------------------------------------------------
    assign eq_a = cnt_q == cmp0_q;
    assign eq_b = cnt_q == cmp1_q;
    assign wrap = cnt_q == `TECC_CNT_MAX;
    assign o_match_a = channel_run && eq_a;
    assign o_match_b = channel_run && eq_b;
    assign o_match_irq_a  = o_match_a && !eq_a_q;
    assign o_match_irq_b  = o_match_b && !eq_b_q;
    assign o_overflow_irq = channel_run && tick && wrap && !(clear_en && eq_b);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !channel_run) begin
            cnt_q <= 16'h0000;
        end else if (tick) begin
            if (clear_en && eq_b) begin
                cnt_q <= 16'h0000;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            eq_a_q <= 1'b0;
            eq_b_q <= 1'b0;
        end else begin
            eq_a_q <= o_match_a;
            eq_b_q <= o_match_b;
        end
    end

    // ------------------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------------------
    tecc_capture #(
        .HAS_PINS (HAS_EXT_PINS)
    ) u_cap (
        .i_clk        (i_clk),
        .i_sys_rst    (i_sys_rst),
        .i_mode       (mode_q[`TECC_MODE_CPM_LSB +: 2]),
        .i_companion  (i_companion_timer_output),
        .i_pin        (i_capture_input_pin),
        .i_tick       (tick && channel_run),
        .i_sw_capture (sw_capture),
        .i_count      (cnt_q),
        .o_cap0       (cap0),
        .o_cap1       (cap1),
        .o_ext_irq    (o_routed_ext_irq)
    );

    // ------------------------------------------------------------------------
    // Status and read data
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            status_q <= 8'h00;
        end else begin
            if (wr_en && idx == `TECC_IDX_STATUS && mapped) begin
                status_q <= status_q & ~i_pwdata[7:0];
            end
            if (o_overflow_irq) begin
                status_q[`TECC_ST_OVF_BIT] <= 1'b1;
            end
            if (o_match_irq_a) begin
                status_q[`TECC_ST_MA_BIT] <= 1'b1;
            end
            if (o_match_irq_b) begin
                status_q[`TECC_ST_MB_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_q   <= 32'h00000000;
            err_q     <= 1'b0;
            cap0_hi_q <= 8'h00;
            cap1_hi_q <= 8'h00;
        end else if (i_psel && !i_penable) begin
            err_q   <= !mapped;
            rdata_q <= 32'h00000000;
            if (rd_setup && mapped) begin
                if (idx == `TECC_IDX_RUN) begin
                    rdata_q <= {24'h000000, run_q};
                end else if (idx == `TECC_IDX_MODE) begin
                    rdata_q <= {24'h000000, mode_q};
                end else if (idx == `TECC_IDX_STATUS) begin
                    rdata_q <= {24'h000000, status_q};
                end else if (idx == `TECC_IDX_CAP0_LO) begin
                    rdata_q   <= {24'h000000, cap0[7:0]};
                    cap0_hi_q <= cap0[15:8];
                end else if (idx == `TECC_IDX_CAP0_HI) begin
                    rdata_q <= {24'h000000, cap0_hi_q};
                end else if (idx == `TECC_IDX_CAP1_LO) begin
                    rdata_q   <= {24'h000000, cap1[7:0]};
                    cap1_hi_q <= cap1[15:8];
                end else if (idx == `TECC_IDX_CAP1_HI) begin
                    rdata_q <= {24'h000000, cap1_hi_q};
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_presc_held_clear: assert property (!prescaler_run |=> pre_count == 5'h00)
        else $error("Prescaler not cleared while stopped.");
    a_base_every_four: assert property (base_tick && prescaler_run |=> !base_tick [*3])
        else $error("Prescaler input tick spacing wrong.");
    a_tap_nesting: assert property (tap_coarse |-> tap_medium && tap_fine)
        else $error("Coarse tap not aligned with finer taps.");
    a_count_step: assert property (channel_run && tick && !(clear_en && eq_b) && !wrap
        ##1 channel_run |-> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("Counter did not step on its tick.");
    a_stop_clears: assert property (!channel_run |=> cnt_q == 16'h0000)
        else $error("Stopped counter not zero.");
    a_clear_match: assert property (channel_run && tick && clear_en && eq_b |=> cnt_q == 16'h0000)
        else $error("Counter not cleared on compare one match.");
    a_ovf_wraps: assert property (o_overflow_irq ##1 channel_run |-> cnt_q == 16'h0000)
        else $error("Overflow did not wrap counter.");
    a_match_cause: assert property (channel_run && tick && !(clear_en && eq_b) && !eq_a &&
        cnt_q + 16'h0001 == cmp0_q ##1 channel_run && $stable(cmp0_q) |-> o_match_irq_a)
        else $error("Match interrupt missing on equality.");
    a_dbuf_copy: assert property (dbuf_en && o_match_irq_b && !wr_en |=> cmp0_q == $past(buf0_q))
        else $error("Buffer not copied into compare zero.");
    a_irq_single: assert property (o_match_irq_b |=> !o_match_irq_b)
        else $error("Match interrupt longer than one cycle.");
    a_cmp_readzero: assert property (i_psel && !i_penable && idx == `TECC_IDX_CMP0_LO
        |=> o_prdata == 32'h00000000)
        else $error("Compare register readable.");
    a_sw_capture: assert property (sw_capture |=> cap0 == $past(cnt_q))
        else $error("Software capture did not load the counter.");
    a_buf_only: assert property (wr_en && mapped && idx == `TECC_IDX_CMP0_HI && dbuf_en
        |=> cmp0_q == $past(cmp0_q))
        else $error("Buffered write reached compare zero.");
    a_status_set: assert property (o_match_irq_b |=> status_q[`TECC_ST_MB_BIT])
        else $error("Match b status not set.");
    a_ovf_single: assert property (o_overflow_irq |=> !o_overflow_irq)
        else $error("Overflow interrupt longer than one cycle.");
    a_unmapped_err: assert property (i_psel && i_penable && $stable(i_paddr) && !mapped
        |-> o_pslverr)
        else $error("Unmapped access without error response.");

    // ------------------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------------------
    c_overflow: cover property (o_overflow_irq);
    c_dbuf_copy: cover property (dbuf_en && o_match_irq_b);
    c_capture: cover property (channel_run && o_routed_ext_irq);
    c_sw_capture: cover property (sw_capture);
    c_buf_write: cover property (wr_en && mapped && idx == `TECC_IDX_CMP0_HI && dbuf_en);
endmodule : tecc_channel

//--- rtl/tecc_params.svh
/*
 * Offsets, field positions, reset values and counts of the timer/event counter channel.
 * Assumes it is included by bare name from every file that needs it.
 */
`ifndef TECC_PARAMS_SVH
`define TECC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define TECC_IDX_RUN        14'h1180
`define TECC_IDX_MODE       14'h1182
`define TECC_IDX_STATUS     14'h1184
`define TECC_IDX_CMP0_LO    14'h1188
`define TECC_IDX_CMP0_HI    14'h1189
`define TECC_IDX_CMP1_LO    14'h118a
`define TECC_IDX_CMP1_HI    14'h118b
`define TECC_IDX_CAP0_LO    14'h118c
`define TECC_IDX_CAP0_HI    14'h118d
`define TECC_IDX_CAP1_LO    14'h118e
`define TECC_IDX_CAP1_HI    14'h118f

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TECC_RUN_CH_BIT     0
`define TECC_RUN_PRE_BIT    2
`define TECC_RUN_RDE_BIT    7
`define TECC_MODE_CLK_LSB   0
`define TECC_MODE_CLE_BIT   2
`define TECC_MODE_CPM_LSB   3
`define TECC_MODE_SWC_BIT   5
`define TECC_ST_OVF_BIT     0
`define TECC_ST_MA_BIT      1
`define TECC_ST_MB_BIT      2

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define TECC_RUN_RESET      8'h00
`define TECC_MODE_RESET     8'h20
`define TECC_CNT_MAX        16'hffff
`define TECC_PCLK_DIV_LAST  2'h3
`define TECC_TAP_FINE_MASK  5'h01
`define TECC_TAP_MED_MASK   5'h07
`define TECC_TAP_COARSE_MASK 5'h1f

`endif

//--- rtl/tecc_pkg.sv
/*
 * Types shared by the timer/event counter channel.
 * Assumes nothing of its surroundings.
 */
package tecc_pkg;

    typedef enum logic [1:0] {
        TECC_SRC_EXT,
        TECC_SRC_FINE,
        TECC_SRC_MED,
        TECC_SRC_COARSE
    } tecc_src_t;

    typedef enum logic [1:0] {
        TECC_CAP_OFF,
        TECC_CAP_PIN,
        TECC_CAP_RSVD,
        TECC_CAP_COMPANION
    } tecc_capm_t;

endpackage : tecc_pkg

//--- rtl/tecc_prescaler.sv
/*
 * Divide-by-four base tick and 5-bit prescaler with three taps.
 * Assumes one clock, synchronous active-high reset.
 */
`timescale 1ns/100ps
`include "tecc_params.svh"

module tecc_prescaler
    import tecc_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_run,
    output logic            o_base_tick,
    output logic            o_tap_fine,
    output logic            o_tap_medium,
    output logic            o_tap_coarse,
    output logic [4:0]      o_count
);
    logic [1:0] div_q;
    logic [4:0] pre_q;

    assign o_base_tick  = i_run && (div_q == `TECC_PCLK_DIV_LAST);
    assign o_tap_fine   = o_base_tick && ((pre_q & `TECC_TAP_FINE_MASK) == `TECC_TAP_FINE_MASK);
    assign o_tap_medium = o_base_tick && ((pre_q & `TECC_TAP_MED_MASK) == `TECC_TAP_MED_MASK);
    assign o_tap_coarse = o_base_tick && (pre_q == `TECC_TAP_COARSE_MASK);
    assign o_count      = pre_q;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !i_run) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !i_run) begin
            pre_q <= 5'h00;
        end else if (o_base_tick) begin
            pre_q <= pre_q + 5'h01;
        end
    end
endmodule : tecc_prescaler

//--- tb/tecc_testbench.sv
/*
 * Self-checking bench for the timer/event counter channel, driven over APB.
 * Assumes one 100 MHz clock and a synchronous active-high reset; the master waits for pready.
 */
`timescale 1ns/100ps
`include "tecc_params.svh"

module testbench
    import tecc_pkg::*;
;
    // ------------------------------------------------------------------------
    // Signals and design instance
    // ------------------------------------------------------------------------
    logic        i_clk;
    logic        i_sys_rst;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic        ext_clk, cap_pin, comp, ma, mb, ia, ib, iov, iext, e;
    int          errors, checked, cyc, na, nb, ne, ta, tb, t0, t1, a0;

    tecc_channel tecc_channel_inst (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_ext_clock_pin(ext_clk),
        .i_capture_input_pin(cap_pin), .i_companion_timer_output(comp),
        .o_match_a(ma), .o_match_b(mb), .o_match_irq_a(ia), .o_match_irq_b(ib),
        .o_overflow_irq(iov), .o_routed_ext_irq(iext)
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Counts match and external interrupt pulses and stamps the cycle of each match pulse.
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (ia === 1'b1) begin
            na <= na + 1;
            ta <= cyc;
        end
        if (ib === 1'b1) begin
            nb <= nb + 1;
            tb <= cyc;
        end
        if (iext === 1'b1) ne <= ne + 1;
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic xfer(input logic [13:0] idx, input logic wr_n, input logic [7:0] wd,
                        output logic [31:0] rd_d, output logic err);
        @(posedge i_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_n;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        rd_d = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [13:0] idx, input logic [7:0] v);
        logic [31:0] x;
        logic        er;
        xfer(idx, 1'b1, v, x, er);
    endtask : wr

    task automatic rdc(input logic [13:0] idx, input logic [31:0] exp, input string msg);
        logic [31:0] x;
        logic        er;
        xfer(idx, 1'b0, 8'h00, x, er);
        chk(x, exp, msg);
    endtask : rdc

    task automatic wcmp(input logic [13:0] lo, input logic [15:0] v);
        wr(lo, v[7:0]);
        wr(lo + 14'h1, v[15:8]);
    endtask : wcmp

    task automatic wait_irq(input bit which, output int stamp);
        int s;
        int n;
        s = which ? nb : na;
        for (n = 0; n < 3000; n++) begin
            @(posedge i_clk);
            #1;
            if ((which ? nb : na) != s) break;
        end
        chk(32'(n < 3000), 32'h1, "interrupt wait");
        stamp = which ? tb : ta;
    endtask : wait_irq

    task automatic ext_pulse(input int k);
        repeat (k) begin
            @(posedge i_clk);
            ext_clk <= 1'b1;
            repeat (3) @(posedge i_clk);
            ext_clk <= 1'b0;
            repeat (3) @(posedge i_clk);
        end
    endtask : ext_pulse

    task end_of_test;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, ext_clk, cap_pin, comp} = 6'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        {errors, checked, cyc, na, nb, ne, ta, tb} = '0;
        i_sys_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rdc(`TECC_IDX_RUN, 32'h00, "run reset");
        rdc(`TECC_IDX_MODE, 32'h20, "mode reset");
        rdc(`TECC_IDX_CMP0_LO, 32'h00, "compare read");
        xfer(14'h1190, 1'b0, 8'h00, d, e);
        chk({31'h0, e}, 32'h1, "unmapped error");
        chk(d, 32'h0, "unmapped read");
        $display("test registers done");
        wcmp(`TECC_IDX_CMP0_LO, 16'h0003);
        wcmp(`TECC_IDX_CMP1_LO, 16'h0005);
        for (int s = 1; s < 4; s++) begin
            wr(`TECC_IDX_MODE, 8'h24 | 8'(s));
            wr(`TECC_IDX_RUN, 8'h05);
            wait_irq(1'b1, t0);
            a0 = na;
            wait_irq(1'b1, t1);
            chk(32'(t1 - t0), 32'(48 << (2 * (s - 1))), "tap period");
            chk(32'(na - a0), 32'h1, "match a per period");
            wr(`TECC_IDX_RUN, 8'h00);
        end
        rdc(`TECC_IDX_STATUS, 32'h06, "status bits");
        wr(`TECC_IDX_STATUS, 8'h06);
        rdc(`TECC_IDX_STATUS, 32'h00, "status clear");
        $display("test taps done");
        wcmp(`TECC_IDX_CMP0_LO, 16'h0010);
        wr(`TECC_IDX_MODE, 8'h21);
        wr(`TECC_IDX_RUN, 8'h05);
        wait_irq(1'b0, t0);
        wr(`TECC_IDX_MODE, 8'h01);
        rdc(`TECC_IDX_CAP0_LO, 32'h10, "capture low");
        rdc(`TECC_IDX_CAP0_HI, 32'h00, "capture high");
        wr(`TECC_IDX_RUN, 8'h00);
        $display("test software capture done");
        wcmp(`TECC_IDX_CMP0_LO, 16'h0002);
        wcmp(`TECC_IDX_CMP1_LO, 16'h0008);
        wr(`TECC_IDX_MODE, 8'h25);
        wr(`TECC_IDX_RUN, 8'h05);
        wait_irq(1'b1, t0);
        wait_irq(1'b0, t1);
        chk(32'(t1 - t0), 32'd24, "compare direct");
        wr(`TECC_IDX_RUN, 8'h85);
        wait_irq(1'b0, t0);
        a0 = na;
        wcmp(`TECC_IDX_CMP0_LO, 16'h0004);
        wait_irq(1'b1, t0);
        chk(32'(na - a0), 32'h0, "buffer only");
        wait_irq(1'b0, t1);
        chk(32'(t1 - t0), 32'd40, "buffer copy");
        wr(`TECC_IDX_RUN, 8'h00);
        $display("test double buffer done");
        wcmp(`TECC_IDX_CMP1_LO, 16'h0003);
        wr(`TECC_IDX_MODE, 8'h2c);
        wr(`TECC_IDX_RUN, 8'h01);
        a0 = nb;
        ext_pulse(4);
        chk(32'(nb - a0), 32'h1, "external clock");
        a0 = ne;
        @(posedge i_clk) cap_pin <= 1'b1;
        repeat (6) @(posedge i_clk);
        cap_pin <= 1'b0;
        repeat (6) @(posedge i_clk);
        chk(32'(ne - a0), 32'h1, "rising edge irq");
        $display("test pins done");
        wr(`TECC_IDX_RUN, 8'h00);
        wr(`TECC_IDX_MODE, 8'h38);
        wr(`TECC_IDX_RUN, 8'h01);
        ext_pulse(2);
        comp <= 1'b1;
        ext_pulse(1);
        comp <= 1'b0;
        ext_pulse(1);
        chk({31'h0, ma}, 32'h1, "match a level");
        chk({31'h0, mb}, 32'h0, "match b level");
        rdc(`TECC_IDX_CAP0_LO, 32'h02, "companion rise capture");
        rdc(`TECC_IDX_CAP1_LO, 32'h03, "companion fall capture");
        rdc(`TECC_IDX_CAP1_HI, 32'h00, "capture one high");
        wr(`TECC_IDX_RUN, 8'h00);
        $display("test companion capture done");
        end_of_test();
    end

    initial begin
        #300000;
        errors++;
        end_of_test();
    end

endmodule : testbench
